// ===== verilog/fgt_cfg.svh
// Purpose: Offsets, field positions, reset values for the fetch guard timer
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes: Included by the top module
`ifndef FGT_CFG_SVH
`define FGT_CFG_SVH
`define FGT_OFF_CONTROL 12'h000
`define FGT_OFF_COUNT 12'h004
`define FGT_OFF_MATCH 12'h008
`define FGT_OFF_STATUS 12'h00c
`define FGT_OFF_MASK 12'h010
`define FGT_CTRL_ON_BIT 0
`define FGT_STAT_TRIP_BIT 0
`define FGT_STAT_MASK 32'h0000_0001
`define FGT_CTRL_RESET 32'h0000_0000
`define FGT_MASK_RESET 32'h0000_0000
`define FGT_RESP_OKAY 2'b00
`define FGT_RESP_SLVERR 2'b10
`endif

// ===== verilog/fgt_pkg.sv
// Purpose: Types shared by the fetch guard timer
// Assumes: Offsets and constants come from fgt_cfg.svh
// Notes: Match value is two 16-bit fuse halves
package fgt_pkg;
	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
	} fgt_match_type;
	typedef enum logic [0:0] {
		fgt_counting = 1'b0,
		fgt_tripped = 1'b1
	} fgt_state_type;
endpackage : fgt_pkg

// ===== verilog/fgt_timer.sv
// Purpose: Fetch counting guard timer that resets the core on a count match
// Assumes: Fetch pulse and fuses synchronous to ref_clk_i; AXI4-Lite master
// Notes: Request holds until device reset; registers reached over AXI4-Lite
// A zero match value trips on the first active edge; fuse halves are read live
// Contract
// - The timer requests a processor reset when its count reaches the match value.
// - The count advances by one only in cycles with an instruction fetch.
// - The count holds between fetches and stops once the count equals the match.
// - In sleep no fetches occur, so the count holds its value.
// - The timer is active if the fuse enable is set or software sets the enable bit.
// - The counter is 32 bits and the match is built from two 16-bit fuse words.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`include "fgt_cfg.svh"
module fgt_timer
	import fgt_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic fetch_i,
	input wire logic sleep_i,
	input wire logic fuse_enable_i,
	input wire logic [15:0] match_value_low_fuse_i,
	input wire logic [15:0] match_value_high_fuse_i,
	output logic core_reset_req_o,
	output logic irq_o,
	input wire logic [ADDR_W-1:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic [ADDR_W-1:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i
);
	// Offsets are 12-bit; under 5 bits would cut the decode, over 12 would overrun it
	if (ADDR_W < 5 || ADDR_W > 12) begin : g_chk
		$error("ADDR_W outside what the register map can serve");
	end

	// Timer state
	fgt_match_type match;
	fgt_state_type state, next_state;
	logic [31:0] count, next_count;
	logic ctrl_on, next_ctrl_on;
	logic stat, next_stat;
	logic mask, next_mask;
	logic active;
	logic irq, next_irq;
	// Bus response registers
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic wr_fire, rd_fire, trip_evt, clr_hit;

	// Compare an address to a register offset
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] off);
		addr_is = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction : addr_is

	// Match assembled from the two fuse halves
	assign match.low = match_value_low_fuse_i;
	assign match.high = match_value_high_fuse_i;
	// Either enable source runs the timer; neither can undo a trip
	assign active = fuse_enable_i | ctrl_on;

	// Counter and trip state; the match is tested before a fetch so it never overshoots
	always_comb begin
		next_count = count;
		next_state = state;
		trip_evt = 1'h0;
		unique case (state)
			fgt_counting: begin
				// Idle while neither enable is set
				if (active) begin
					if (count == match) begin
						next_state = fgt_tripped;
						trip_evt = 1'h1;
					end else if (fetch_i && !sleep_i) begin
						next_count = count + 32'h0000_0001;
					end
				end
			end
			fgt_tripped: begin
				// Held until a device reset; software cannot rearm it
				next_state = fgt_tripped;
			end
		endcase
	end

	// Count and state clear together so counting restarts from zero
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= 32'h0000_0000;
			state <= fgt_counting;
		end else begin
			count <= next_count;
			state <= next_state;
		end
	end

	// The request is the state bit itself, so it cannot glitch
	assign core_reset_req_o = (state == fgt_tripped);

	// Bus slave: write takes address and data together, read one at a time
	// Taking both write channels at once spares a holding register for either
	assign s_awready_o = s_awvalid_i & s_wvalid_i & ~bvalid;
	assign s_wready_o = s_awready_o;
	assign wr_fire = s_awready_o;
	assign s_arready_o = ~rvalid;
	assign rd_fire = s_arvalid_i & ~rvalid;
	// Write-one clear of the trip status bit
	assign clr_hit = wr_fire && addr_is(s_awaddr_i, `FGT_OFF_STATUS) && s_wstrb_i[0]
		&& s_wdata_i[`FGT_STAT_TRIP_BIT];

	// Write side: control and mask bits take written data; the status bit only clears on a written one
	always_comb begin
		next_ctrl_on = ctrl_on;
		next_mask = mask;
		next_bvalid = bvalid;
		next_bresp = bresp;
		// Set wins over a simultaneous write-one clear
		next_stat = trip_evt | (stat & ~clr_hit);
		// Response leaves at its own handshake
		if (bvalid && s_bready_i) begin
			next_bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_bvalid = 1'b1;
			next_bresp = `FGT_RESP_OKAY;
			if (addr_is(s_awaddr_i, `FGT_OFF_CONTROL)) begin
				if (s_wstrb_i[0]) begin
					next_ctrl_on = s_wdata_i[`FGT_CTRL_ON_BIT];
				end
			end else if (addr_is(s_awaddr_i, `FGT_OFF_MASK)) begin
				if (s_wstrb_i[0]) begin
					next_mask = s_wdata_i[`FGT_STAT_TRIP_BIT];
				end
			end else if (!addr_is(s_awaddr_i, `FGT_OFF_STATUS)
				&& !addr_is(s_awaddr_i, `FGT_OFF_COUNT)
				&& !addr_is(s_awaddr_i, `FGT_OFF_MATCH)) begin
				next_bresp = `FGT_RESP_SLVERR;
			end
		end
		// Registered from next values so the level rises with its status bit
		next_irq = next_stat & next_mask;
	end

	// Read data is caught when taken and stands until rready
	always_comb begin
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		// Read answer leaves at its own handshake
		if (rvalid && s_rready_i) begin
			next_rvalid = 1'b0;
		end
		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rresp = `FGT_RESP_OKAY;
			next_rdata = 32'h0000_0000;
			if (addr_is(s_araddr_i, `FGT_OFF_CONTROL)) begin
				next_rdata[`FGT_CTRL_ON_BIT] = ctrl_on;
			end else if (addr_is(s_araddr_i, `FGT_OFF_COUNT)) begin
				next_rdata = count;
			end else if (addr_is(s_araddr_i, `FGT_OFF_MATCH)) begin
				next_rdata = match;
			end else if (addr_is(s_araddr_i, `FGT_OFF_STATUS)) begin
				next_rdata[`FGT_STAT_TRIP_BIT] = stat;
			end else if (addr_is(s_araddr_i, `FGT_OFF_MASK)) begin
				next_rdata[`FGT_STAT_TRIP_BIT] = mask;
			end else begin
				next_rresp = `FGT_RESP_SLVERR;
			end
		end
	end

	// Bus and interrupt registers; control bit is lost on any device reset
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_on <= 1'b0;
			stat <= 1'b0;
			mask <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
			rvalid <= 1'b0;
			rresp <= 2'b00;
			rdata <= 32'h0000_0000;
			irq <= 1'h0;
		end else begin
			ctrl_on <= next_ctrl_on;
			stat <= next_stat;
			mask <= next_mask;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			irq <= next_irq;
		end
	end

	assign irq_o = irq;
	// Bus outputs come straight from their registers
	assign s_bvalid_o = bvalid;
	assign s_bresp_o = bresp;
	assign s_rvalid_o = rvalid;
	assign s_rresp_o = rresp;
	assign s_rdata_o = rdata;
endmodule : fgt_timer

// ===== verification/fgt_props.sv
// Purpose: Port checks for the fetch guard timer
// Assumes: One clock, asynchronous active-low reset
// Notes: Count is internal, so trips are judged by the bench
module fgt_props (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic core_reset_req_o,
	input wire logic s_awvalid_i,
	input wire logic s_wvalid_i,
	input wire logic s_awready_o,
	input wire logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic [1:0] s_bresp_o,
	input wire logic s_arvalid_i,
	input wire logic s_rvalid_o,
	input wire logic s_rready_i
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Only a device reset may drop the request
	chk_req_sticky: assert property (core_reset_req_o |=> core_reset_req_o)
		else $error("reset request dropped");
	chk_req_restart: assert property (!$past(arst_n_i) |-> !core_reset_req_o)
		else $error("request seen right after reset");
	// Bus answers one cycle after taking, then holds
	chk_wr_answer: assert property (s_awvalid_i && s_wvalid_i && !s_bvalid_o |=> s_bvalid_o)
		else $error("write answer late");
	chk_b_hold: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
		else $error("write answer not held");
	chk_b_refuse: assert property (s_bvalid_o |-> !s_awready_o)
		else $error("write taken while answer pending");
	chk_rd_answer: assert property (s_arvalid_i && !s_rvalid_o |=> s_rvalid_o)
		else $error("read answer late");
	chk_r_hold: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o)
		else $error("read answer not held");
	cover property (core_reset_req_o);
	cover property (s_bvalid_o && s_bready_i);
	cover property (s_rvalid_o && s_rready_i);
endmodule : fgt_props

// ===== verification/fgt_fetch_model.sv
// Purpose: Fetch unit stand-in giving one pulse per fetch
// Assumes: Fetches change right after the clock edge
// Notes: Slow mode mimics a stalling pipeline
module fgt_fetch_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic slow_i,
	output logic fetch_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ph = 1'b0;
	initial fetch_o = 1'b0;
	// Every cycle, or every other cycle when slow
	always @(posedge clk_i) begin
		ph <= ~ph;
		fetch_o <= go_i && (!slow_i || ph);
	end
endmodule : fgt_fetch_model

// ===== verification/fetch_count_deadman_timer_bench.sv
// Purpose: Self-checking bench for the fetch guard timer
// Assumes: Match values three and eight, so trips come quickly
// Notes: Registers reached over AXI4-Lite
module fetch_count_deadman_timer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin n_errors++; \
		$display("mismatch %s exp %0h got %0h", n, e, v); end end
	int n_errors = 0;
	int checks = 0;
	logic clk = 0, rst_n = 0, sleep = 0, fen = 0, go = 0, slow = 0;
	logic [15:0] lo = 0, hi = 0;
	logic [11:0] aw = 0, ar = 0;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [31:0] wd = 0, rd;
	logic [1:0] br, rr;
	logic fetch, req, irq, awr, wrdy, bv, arr, rv;
	// Clock at 20 MHz
	always #25 clk = ~clk;
	fgt_fetch_model fm_u (.clk_i(clk), .go_i(go), .slow_i(slow), .fetch_o(fetch));
	fgt_timer dut_u (.ref_clk_i(clk), .arst_n_i(rst_n), .fetch_i(fetch), .sleep_i(sleep),
		.fuse_enable_i(fen), .match_value_low_fuse_i(lo), .match_value_high_fuse_i(hi),
		.core_reset_req_o(req), .irq_o(irq), .s_awaddr_i(aw), .s_awvalid_i(awv),
		.s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'hf), .s_wvalid_i(wv),
		.s_wready_o(wrdy), .s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(bre),
		.s_araddr_i(ar), .s_arvalid_i(arv), .s_arready_o(arr), .s_rdata_o(rd),
		.s_rresp_o(rr), .s_rvalid_o(rv), .s_rready_i(rre));
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do @(posedge clk); while (!(awr && wrdy));
		awv <= 1'b0;
		wv <= 1'b0;
		bre <= 1'b1;
		do @(posedge clk); while (!bv);
		bre <= 1'b0;
		`CHK("bresp", 2'h0, br)
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		ar <= a;
		arv <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		rre <= 1'b1;
		do @(posedge clk); while (!rv);
		rre <= 1'b0;
		`CHK("rdata", e, rd)
		`CHK("rresp", er, rr)
	endtask : rdc
	task automatic t_soft;
		lo <= 16'h0003;
		hi <= 16'h00a5;
		rdc(12'h000, 32'h0, 2'h0);
		rdc(12'h008, 32'h00a5_0003, 2'h0);
		hi <= 16'h0000;
		go <= 1'b1;
		sleep <= 1'b1;
		repeat (5) @(posedge clk);
		rdc(12'h004, 32'h0, 2'h0);
		wr(12'h000, 32'h1);
		repeat (5) @(posedge clk);
		rdc(12'h004, 32'h0, 2'h0);
		sleep <= 1'b0;
		repeat (20) @(posedge clk);
		`CHK("req", 1'b1, req)
		rdc(12'h004, 32'h3, 2'h0);
		rdc(12'h00c, 32'h1, 2'h0);
		`CHK("irq", 1'b0, irq)
		wr(12'h010, 32'h1);
		`CHK("irq", 1'b1, irq)
		wr(12'h00c, 32'h1);
		`CHK("irq", 1'b0, irq)
		rdc(12'h014, 32'h0, 2'h2);
	endtask : t_soft
	task automatic t_fuse;
		go <= 1'b0;
		rst_n <= 1'b0;
		@(posedge clk);
		`CHK("req", 1'b0, req)
		rst_n <= 1'b1;
		fen <= 1'b1;
		lo <= 16'h0008;
		repeat (10) @(posedge clk);
		rdc(12'h004, 32'h0, 2'h0);
		slow <= 1'b1;
		go <= 1'b1;
		// Eight model edges with go high give exactly four fetches
		repeat (8) @(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
		rdc(12'h004, 32'h4, 2'h0);
		`CHK("req", 1'b0, req)
		go <= 1'b1;
		repeat (20) @(posedge clk);
		`CHK("req", 1'b1, req)
		rdc(12'h004, 32'h8, 2'h0);
	endtask : t_fuse
	task automatic results;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	// Main sequence after three reset cycles
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_soft();
		t_fuse();
		results();
	end
	// Watchdog well beyond the hundred or so cycles needed
	initial begin
		#100us;
		n_errors++;
		results();
	end
endmodule : fetch_count_deadman_timer_bench
bind fgt_timer fgt_props props_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
	.core_reset_req_o(core_reset_req_o), .s_awvalid_i(s_awvalid_i), .s_wvalid_i(s_wvalid_i),
	.s_awready_o(s_awready_o), .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
	.s_bresp_o(s_bresp_o), .s_arvalid_i(s_arvalid_i), .s_rvalid_o(s_rvalid_o),
	.s_rready_i(s_rready_i));
